/* pkg/i2cpra_pkg.sv */
// constants and carrier types of the paged i2c register access block
package i2cpra_pkg;
  localparam logic [6:0] I2CPRA_ADDR_NORMAL    = 7'h4e;  // 1001110
  localparam logic [6:0] I2CPRA_ADDR_BROADCAST = 7'h4c;  // 1001100
  localparam logic [6:0] I2CPRA_REG_PAGE       = 7'h00;  // page select index
  localparam logic [7:0] I2CPRA_PAGE_RESET     = 8'h00;
  localparam int         I2CPRA_PAGE_SIZE      = 128;
  localparam logic [2:0] I2CPRA_BIT_LAST       = 3'h7;
  localparam logic [3:0] I2CPRA_REQ_GAP        = 4'h2;   // core-clock edges between requests

  // write request carried from the link domain to the core domain
  typedef struct packed {
    logic [7:0] page;
    logic [6:0] index;
    logic [7:0] data;
  } i2cpra_wreq_s;

  // link-side state machine
  typedef enum logic [2:0] {
    I2CPRA_IDLE  = 3'b000,
    I2CPRA_ADDR  = 3'b001,
    I2CPRA_AACK  = 3'b010,
    I2CPRA_RXB   = 3'b011,
    I2CPRA_RACK  = 3'b100,
    I2CPRA_TXB   = 3'b101,
    I2CPRA_TACK  = 3'b110,
    I2CPRA_IGN   = 3'b111
  } i2cpra_state_e;
endpackage : i2cpra_pkg

/* design/i2cpra_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ns
module i2cpra_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : i2cpra_sync

/* design/i2cpra_top.sv */
// i2c target with paged 8-bit register space
`timescale 1ns/1ns
module i2cpra_top (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       broadcast_address_enable,
  input  wire logic       sw_reset,
  output logic [7:0]      page_q,
  output logic            wr_valid_q,
  output logic [7:0]      wr_page_q,
  output logic [6:0]      wr_index_q,
  output logic [7:0]      wr_data_q,
  output logic [6:0]      rd_index_q,
  input  wire logic [7:0] rd_data
);
  // ---------------- link domain (scl_clk) ----------------
  i2cpra_pkg::i2cpra_state_e state_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q;
  logic        first_q;       // next received byte is the index
  logic        rw_q;
  logic [6:0]  index_q;
  logic [7:0]  tx_q;
  logic        sda_drv_q;
  logic        wtog_q;
  i2cpra_pkg::i2cpra_wreq_s wreq_q;
  logic        start_tog_q;
  logic        stop_tog_q;
  logic        start_seen_q;
  logic        stop_seen_q;
  logic [1:0]  bcast_l;
  logic [7:0]  page_l_q;      // page shadow, updated on link side writes
  logic [1:0]  pgrst_l;
  logic        oe_s;          // sda drive request seen in the core clock

  wire [7:0] byte_in    = {shift_q[6:0], sda_in};
  wire [6:0] my_addr    = bcast_l[1] ? i2cpra_pkg::I2CPRA_ADDR_BROADCAST
                                     : i2cpra_pkg::I2CPRA_ADDR_NORMAL;
  wire       addr_hit   = (byte_in[7:1] == my_addr);
  wire       byte_done  = (bit_q == i2cpra_pkg::I2CPRA_BIT_LAST);
  wire       is_page    = (index_q == i2cpra_pkg::I2CPRA_REG_PAGE);
  wire [7:0] rd_byte    = is_page ? page_l_q : rd_data;
  // a start or stop toggles at an sda edge while scl is high
  wire       start_pend = start_tog_q != start_seen_q;
  wire       stop_pend  = stop_tog_q != stop_seen_q;

  // start and stop detection; sda edges act as a clock, an accepted trade-off for small area
  // a falling sda while scl is high is a start or repeated start
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_tog_q <= 1'b0;
    end else if (scl_clk) begin
      start_tog_q <= ~start_tog_q;
    end
  end
  // a rising sda while scl is high is a stop
  always_ff @(posedge sda_in or posedge reset) begin
    if (reset) begin
      stop_tog_q <= 1'b0;
    end else if (scl_clk) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // broadcast strap and page reset reach the link clock through two flops
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      bcast_l <= 2'b00;
      pgrst_l <= 2'b00;
    end else begin
      bcast_l <= {bcast_l[0], broadcast_address_enable};
      pgrst_l <= {pgrst_l[0], sw_reset};
    end
  end

  // receive and state progress on the rising scl edge
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      state_q      <= i2cpra_pkg::I2CPRA_IDLE;
      bit_q        <= 3'h0;
      shift_q      <= 8'h00;
      first_q      <= 1'b0;
      rw_q         <= 1'b0;
      index_q      <= 7'h00;
      wtog_q       <= 1'b0;
      wreq_q       <= '0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      page_l_q     <= i2cpra_pkg::I2CPRA_PAGE_RESET;
    end else begin
      start_seen_q <= start_tog_q;
      stop_seen_q  <= stop_tog_q;
      if (pgrst_l[1]) page_l_q <= i2cpra_pkg::I2CPRA_PAGE_RESET;
      if (start_pend) begin
        // new start or repeated start ends any transfer; first bit already here
        state_q <= i2cpra_pkg::I2CPRA_ADDR;
        bit_q   <= 3'h1;
        shift_q <= {7'h00, sda_in};
      end else if (stop_pend) begin
        state_q <= i2cpra_pkg::I2CPRA_IDLE;
        bit_q   <= 3'h1;
        shift_q <= {7'h00, sda_in};
      end else begin
        case (state_q)
          i2cpra_pkg::I2CPRA_ADDR, i2cpra_pkg::I2CPRA_RXB: begin
            shift_q <= byte_in;
            bit_q   <= bit_q + 3'h1;
            if (byte_done && state_q == i2cpra_pkg::I2CPRA_ADDR) begin
              rw_q    <= byte_in[0];
              first_q <= ~byte_in[0];
              state_q <= addr_hit ? i2cpra_pkg::I2CPRA_AACK
                                  : i2cpra_pkg::I2CPRA_IGN;
            end else if (byte_done) begin
              state_q <= i2cpra_pkg::I2CPRA_RACK;
              if (first_q) begin
                index_q <= byte_in[6:0];
                first_q <= 1'b0;
              end else begin
                wreq_q  <= '{page: page_l_q, index: index_q, data: byte_in};
                wtog_q  <= ~wtog_q;
                if (is_page) page_l_q <= byte_in;
                index_q <= index_q + 7'h01;
              end
            end
          end
          i2cpra_pkg::I2CPRA_AACK: begin
            bit_q   <= 3'h0;
            state_q <= rw_q ? i2cpra_pkg::I2CPRA_TXB : i2cpra_pkg::I2CPRA_RXB;
          end
          i2cpra_pkg::I2CPRA_RACK: begin
            bit_q   <= 3'h0;
            state_q <= i2cpra_pkg::I2CPRA_RXB;
          end
          // the pointer steps early in the byte so the next read byte
          // has most of a byte time to settle before it is loaded
          i2cpra_pkg::I2CPRA_TXB: begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h0) index_q <= index_q + 7'h01;
            if (byte_done) state_q <= i2cpra_pkg::I2CPRA_TACK;
          end
          i2cpra_pkg::I2CPRA_TACK: begin
            bit_q   <= 3'h0;
            state_q <= sda_in ? i2cpra_pkg::I2CPRA_IGN
                              : i2cpra_pkg::I2CPRA_TXB;
          end
          i2cpra_pkg::I2CPRA_IGN:  state_q <= i2cpra_pkg::I2CPRA_IGN;
          i2cpra_pkg::I2CPRA_IDLE: state_q <= i2cpra_pkg::I2CPRA_IDLE;
          default:                 state_q <= i2cpra_pkg::I2CPRA_IDLE;
        endcase
      end
    end
  end

  // drive sda on the falling scl edge so data is stable while scl is high
  wire ack_slot = (state_q == i2cpra_pkg::I2CPRA_AACK) ||
                  (state_q == i2cpra_pkg::I2CPRA_RACK);
  always_ff @(negedge scl_clk or posedge reset) begin
    if (reset) begin
      sda_drv_q <= 1'b0;
      tx_q      <= 8'h00;
    end else if (ack_slot) begin
      sda_drv_q <= 1'b1;
      tx_q      <= rd_byte;
    end else if (state_q == i2cpra_pkg::I2CPRA_TXB) begin
      sda_drv_q <= ~tx_q[7];
      tx_q      <= {tx_q[6:0], 1'b0};
    end else if (state_q == i2cpra_pkg::I2CPRA_TACK) begin
      // release for the controller's ack, preload the next byte
      sda_drv_q <= 1'b0;
      tx_q      <= rd_byte;
    end else begin
      sda_drv_q <= 1'b0;
    end
  end

  // drive request crosses into the core clock through two flops;
  // the lag must stay well inside the scl low phase
  i2cpra_sync #(.W(1)) u_osync (
    .clk   (clk_sys),
    .reset (reset),
    .d     (sda_drv_q),
    .q     (oe_s)
  );

  // open-drain: only ever pull low
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_oe  <= oe_s;
      sda_out <= 1'b0;
    end
  end

  // ---------------- core domain (clk_sys) ----------------
  logic [0:0] wtog_s;
  logic       wtog_d_q;
  logic [7:0] page_s;
  logic [6:0] idx_s;
  logic [14:0] pi_prev_q;     // last synced page and pointer word

  // write request toggle crosses with two flops; payload changes on the same scl edge as the toggle and then holds a full byte
  i2cpra_sync #(.W(1)) u_wsync (
    .clk   (clk_sys),
    .reset (reset),
    .d     (wtog_q),
    .q     (wtog_s)
  );
  i2cpra_sync #(.W(15)) u_psync (
    .clk   (clk_sys),
    .reset (reset),
    .d     ({page_l_q, index_q}),
    .q     ({page_s, idx_s})
  );

  wire wr_event  = wtog_s[0] != wtog_d_q;
  // a multi-bit word is only taken once two samples agree, so a word
  // caught while it changes never reaches the outputs
  wire pi_steady = ({page_s, idx_s} == pi_prev_q);

  // write strobe and mirrored page, all from flops
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wtog_d_q   <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_page_q  <= 8'h00;
      wr_index_q <= 7'h00;
      wr_data_q  <= 8'h00;
      page_q     <= i2cpra_pkg::I2CPRA_PAGE_RESET;
      rd_index_q <= 7'h00;
      pi_prev_q  <= 15'h0000;
    end else begin
      wtog_d_q   <= wtog_s[0];
      pi_prev_q  <= {page_s, idx_s};
      wr_valid_q <= wr_event;
      if (wr_event) begin
        wr_page_q  <= wreq_q.page;
        wr_index_q <= wreq_q.index;
        wr_data_q  <= wreq_q.data;
      end
      if (pi_steady) begin
        page_q     <= page_s;
        rd_index_q <= idx_s;
      end
    end
  end
endmodule : i2cpra_top

/* bench/i2cpra_props.sv */
// assertions on the ports of the paged i2c register access block
`timescale 1ns/1ns
module i2cpra_props (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       sw_reset,
  input wire logic [7:0] page_q,
  input wire logic       wr_valid_q,
  input wire logic [7:0] wr_page_q,
  input wire logic [6:0] wr_index_q,
  input wire logic [7:0] wr_data_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [7:0] gap_q;
  logic [6:0] last_q;
  // age and index of the last write; a short gap means the same burst
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gap_q  <= 8'hff;
      last_q <= 7'h00;
    end else if (wr_valid_q) begin
      gap_q  <= 8'h00;
      last_q <= wr_index_q;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  sequence s_pulse; wr_valid_q ##1 !wr_valid_q; endsequence
  property p_od; sda_oe |-> !sda_out; endproperty
  property p_rst; $fell(reset) |-> page_q == 8'h00 && !wr_valid_q && !sda_oe; endproperty
  property p_one; wr_valid_q |-> s_pulse ##1 !wr_valid_q [*8]; endproperty
  property p_hold; $changed({wr_page_q, wr_index_q, wr_data_q}) |-> ##[0:1] wr_valid_q; endproperty
  property p_pg; wr_valid_q && wr_index_q == 7'h00 && !sw_reset |-> ##[0:6] page_q == wr_data_q;
  endproperty
  property p_tag; wr_valid_q && wr_index_q != 7'h00 |-> wr_page_q == page_q; endproperty
  property p_inc; wr_valid_q && gap_q < 8'd80 |-> wr_index_q == last_q + 7'h01; endproperty
  property p_sw; $fell(sw_reset) |-> page_q == 8'h00; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_one: assert property (p_one) else $error("write strobe too long");
  a_hold: assert property (p_hold) else $error("payload moved without strobe");
  a_pg: assert property (p_pg) else $error("page not taken from write");
  a_tag: assert property (p_tag) else $error("write tagged with wrong page");
  a_inc: assert property (p_inc) else $error("index did not step");
  a_sw: assert property (p_sw) else $error("page not cleared by soft reset");
endmodule : i2cpra_props
bind i2cpra_top i2cpra_props u_props (.clk_sys, .reset, .sda_out, .sda_oe, .sw_reset, .page_q,
  .wr_valid_q, .wr_page_q, .wr_index_q, .wr_data_q);

/* bench/i2cpra_host.sv */
// behavioural bus controller at the far side of the link
`timescale 1ns/1ns
module i2cpra_host (
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  localparam int LOW = 500;  // long low phase leaves room for the core-clock ack lag
  localparam int HI  = 15;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // start or repeated start: sda falls while scl is high
  task automatic start;
    #HI pull = 1'b0;
    #LOW scl = 1'b1;
    #HI pull = 1'b1;
    #HI scl = 1'b0;
  endtask : start
  // stop leaves scl high, so the link clock stands still between frames
  task automatic stop;
    #HI pull = 1'b1;
    #LOW scl = 1'b1;
    #HI pull = 1'b0;
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    #HI pull = !b;
    #LOW scl = 1'b1;
    #HI r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : recv
endmodule : i2cpra_host

/* bench/test_i2cpra_top.sv */
// self-checking bench for the paged i2c register access block
`timescale 1ns/1ns
module test_i2cpra_top;
  localparam logic [6:0] NM = i2cpra_pkg::I2CPRA_ADDR_NORMAL;
  localparam logic [6:0] BC = i2cpra_pkg::I2CPRA_ADDR_BROADCAST;
  logic        clk_sys = 1'b0, reset = 1'b1, bc_en = 1'b0, sw_rst = 1'b0;
  logic        scl, pull, oe, sda, valid, ack;
  logic [7:0]  page, wp, wd, v, epg = 8'h00, rd_data = 8'h00;
  logic [6:0]  wi, rdi, ix;
  logic [22:0] got[$], exp[$];
  int          miscompares = 0, compares = 0;
  assign sda = !(pull || oe);  // open drain with pull-up
  always #50 clk_sys = !clk_sys;
  i2cpra_host u_host (.scl(scl), .pull(pull), .sda(sda));
  i2cpra_top DUT (.clk_sys(clk_sys), .reset(reset), .scl_clk(scl), .sda_in(sda), .sda_out(),
    .sda_oe(oe), .broadcast_address_enable(bc_en), .sw_reset(sw_rst), .page_q(page),
    .wr_valid_q(valid), .wr_page_q(wp), .wr_index_q(wi), .wr_data_q(wd), .rd_index_q(rdi),
    .rd_data(rd_data));
  function automatic logic [7:0] regval(input logic [6:0] i);
    return {i, 1'b1} ^ 8'h5a;
  endfunction : regval
  // register file behind the pointer; page tag of index 0 writes is masked
  always @(posedge clk_sys) begin
    rd_data <= regval(rdi);
    if (valid === 1'b1) got.push_back({(wi == 7'h00) ? 8'h00 : wp, wi, wd});
  end
  task automatic check(input logic [22:0] s, input logic [22:0] w);
    compares++;
    if (s !== w) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, s, w);
    end
  endtask : check
  task automatic report_and_stop;
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // write n bytes from index i; m says whether address a should answer
  task automatic wr(input logic [6:0] a, input logic [6:0] i, input int n, input logic m);
    u_host.start();
    u_host.send({a, 1'b0}, ack);
    check(23'(ack), 23'(m));
    for (int k = 0; k < n && m; k++) begin
      if (k == 0) u_host.send({1'b0, i}, ack);
      if (k == 0) check(23'(ack), 23'h1);
      ix = i + 7'(k);
      v = (ix == 7'h00) ? 8'($urandom % 5) : 8'($urandom);
      u_host.send(v, ack);
      check(23'(ack), 23'h1);
      exp.push_back({(ix == 7'h00) ? 8'h00 : epg, ix, v});
      if (ix == 7'h00) epg = v;
    end
    u_host.stop();
    repeat (10) @(posedge clk_sys);
    check(23'(got.size()), 23'(exp.size()));
    foreach (exp[k]) if (k < got.size()) check(got[k], exp[k]);
    got = {};
    exp = {};
  endtask : wr
  // set the pointer, then stream n bytes back through a repeated start
  task automatic rd(input logic [6:0] i, input int n);
    u_host.start();
    u_host.send({NM, 1'b0}, ack);
    u_host.send({1'b0, i}, ack);
    check(23'(ack), 23'h1);
    u_host.start();
    u_host.send({NM, 1'b1}, ack);
    check(23'(ack), 23'h1);
    for (int k = 0; k < n; k++) begin
      u_host.recv(k == n - 1, v);
      ix = i + 7'(k);
      check(23'(v), 23'((ix == 7'h00) ? epg : regval(ix)));
    end
    u_host.stop();
    repeat (10) @(posedge clk_sys);
  endtask : rd
  initial begin
    #5000000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h5286));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(23'(page), 23'h0);
    for (int t = 0; t < 6; t++) begin
      bc_en <= t[0];
      wr(t[0] ? NM : BC, 7'h01, 1, 1'b0);
      wr(t[0] ? BC : NM, 7'h00, 1, 1'b1);
      check(23'(page), 23'(epg));
      wr(t[0] ? BC : NM, (t == 2) ? 7'h7e : 7'($urandom_range(100, 1)), 1 + t % 4, 1'b1);
      bc_en <= 1'b0;
      rd(7'($urandom), 1 + t % 3);
    end
    // an ignored frame gives the soft reset its link clock edges
    sw_rst <= 1'b1;
    wr(BC, 7'h01, 1, 1'b0);
    sw_rst <= 1'b0;
    epg = 8'h00;
    check(23'(page), 23'h0);
    rd(7'h00, 2);
    report_and_stop();
  end
endmodule : test_i2cpra_top
